// File: verilog/scx_params.svh
`ifndef SCX_PARAMS_SVH
`define SCX_PARAMS_SVH

// ==========================================================
// Command codes
`define SCX_CMD_NONE       8'h00
`define SCX_CMD_RELEASE    8'h08
`define SCX_CMD_CLOSE      8'h10
`define SCX_CMD_SEND       8'h20
`define SCX_CMD_SEND_NR    8'h21
`define SCX_CMD_KEEP       8'h22

// ==========================================================
// Status codes
`define SCX_ST_SHUT        8'h00
`define SCX_ST_CONNECTED   8'h17
`define SCX_ST_PEER_CLOSE  8'h1C

// ==========================================================
// Protocol modes
`define SCX_MODE_TCP       4'h1
`define SCX_MODE_UDP       4'h2
`define SCX_MODE_RAW_IP    4'h3
`define SCX_MODE_RAW_FRAME 4'h4

// ==========================================================
// Flag bit positions
`define SCX_FLAG_TXDONE    0
`define SCX_FLAG_TIMEOUT   1

// ==========================================================
// Sizes and reset values
`define SCX_SEG_MAX        16'h0040
`define SCX_TX_BUF_BYTES   16'h0100
`define SCX_RAW_LIMIT      16'h003E
`define SCX_FREE_MARGIN    16'h0001
`define SCX_RESET_BYTE     8'h00
`define SCX_RESET_WORD     16'h0000

// ==========================================================
// Timing
`define SCX_CLK_MHZ        10
`define SCX_KEEP_PERIOD_US 10000
`define SCX_KEEP_CYCLES    (`SCX_KEEP_PERIOD_US * `SCX_CLK_MHZ)

`endif

// File: verilog/scx_pkg.sv
package scx_pkg;

    // ==========================================================
    // Device sequencer states
    typedef enum logic [2:0] {
        SCX_D_IDLE  = 3'b001,
        SCX_D_SEND  = 3'b010,
        SCX_D_DRAIN = 3'b100
    } scx_dev_state_t;

    // ==========================================================
    // Host sequencer states
    typedef enum logic [3:0] {
        SCX_H_IDLE  = 4'b0001,
        SCX_H_ISSUE = 4'b0010,
        SCX_H_CLEAR = 4'b0100,
        SCX_H_SENT  = 4'b1000
    } scx_host_state_t;

    // ==========================================================
    // User operations on the host side
    typedef enum logic [2:0] {
        SCX_OP_SEND    = 3'h0,
        SCX_OP_SEND_NR = 3'h1,
        SCX_OP_RELEASE = 3'h2,
        SCX_OP_CLOSE   = 3'h3,
        SCX_OP_KEEP    = 3'h4
    } scx_op_t;

    // ==========================================================
    // Outgoing item kinds and buffer entry
    typedef enum logic [1:0] {
        SCX_K_DATA = 2'h0,
        SCX_K_FIN  = 2'h1,
        SCX_K_KEEP = 2'h2
    } scx_kind_t;

    typedef struct packed {
        scx_kind_t  kind;
        logic       last;
        logic [7:0] data;
    } scx_item_t;

endpackage

// File: verilog/scx_if.sv
`timescale 1ns/10ps

interface scx_if;
    // Host to device
    logic        cmd_wr;
    logic [7:0]  cmd_code;
    logic [3:0]  sock_mode;
    logic [47:0] dest_hw_address;
    logic [15:0] tx_write_pointer;
    logic        buf_wr;
    logic [7:0]  buf_data;
    logic [1:0]  flag_clr;
    // Device to host
    logic [7:0]  socket_command;
    logic [7:0]  socket_status;
    logic [1:0]  socket_interrupt_flags;
    logic [15:0] tx_read_pointer;
    logic [15:0] tx_free_size;

    modport host (
        output cmd_wr, cmd_code, sock_mode, dest_hw_address, tx_write_pointer,
        output buf_wr, buf_data, flag_clr,
        input  socket_command, socket_status, socket_interrupt_flags,
        input  tx_read_pointer, tx_free_size
    );

    modport device (
        input  cmd_wr, cmd_code, sock_mode, dest_hw_address, tx_write_pointer,
        input  buf_wr, buf_data, flag_clr,
        output socket_command, socket_status, socket_interrupt_flags,
        output tx_read_pointer, tx_free_size
    );
endinterface

// File: verilog/scx_device.sv
// Notes on behaviour
// - Disconnect sends FIN in TCP only, when connected or peer-closing
// - Close sets status shut at once
// - Close in TCP sends no FIN
// - Send transmits write minus read pointer bytes
// - Host never queues beyond free size
// - Host waits send-complete before next send
// - TCP and UDP split data into segments
// - Host splits data itself in raw modes
// - TCP peer ack returns sent bytes free
// - TCP no ack sets timeout, shuts socket
// - Other modes free bytes at send-complete
// - Resolution-free send only in UDP/raw IP
// - Host loads hardware address before that send
// - Host sends a byte before keep-alive
// - Keep-alive command starts periodic keep-alive segments
// - Command register clears after execution
`timescale 1ns/10ps
`include "scx_params.svh"

module scx_device
    import scx_pkg::*;
#(
    parameter int KEEP_CYCLES = `SCX_KEEP_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Host side
    scx_if.device            bus,
    // Outgoing items
    output logic             net_valid,
    input  wire logic        net_ready,
    output logic [7:0]       net_data,
    output logic [1:0]       net_kind,
    output logic             net_last,
    output logic             net_skip_resolve,
    output logic [47:0]      net_dest_hw,
    // Peer events
    input  wire logic        peer_ack,
    input  wire logic        peer_timeout,
    input  wire logic        conn_state_valid,
    input  wire logic [7:0]  conn_state
);
    // ==========================================================
    // Helpers
    function automatic logic [15:0] used_bytes(input logic [15:0] w, input logic [15:0] r);
        used_bytes = w - r;
    endfunction
    // ==========================================================
    // State
    logic [7:0]     mem [0:255];
    scx_dev_state_t state;
    scx_item_t      head, tail, item;
    logic [7:0]     cmd_reg, status;
    logic [1:0]     flags;
    logic [15:0]    rd_ptr, free_size, unacked, cur_ptr, remain, seg_cnt, sent_len, start_len;
    logic [31:0]    keep_cnt;
    logic [47:0]    dest_hw;
    logic           seg_mode, pend_fin, keep_on, keep_due, head_v, tail_v, skip_res;
    logic           is_tcp, exec, close_go, send_go, done_go, ack_go, tmo_go, push, pop;

    assign is_tcp    = (bus.sock_mode == `SCX_MODE_TCP);
    assign exec      = (state == SCX_D_IDLE) && (cmd_reg != `SCX_CMD_NONE);
    assign close_go  = (cmd_reg == `SCX_CMD_CLOSE);
    assign send_go   = exec && ((cmd_reg == `SCX_CMD_SEND) || (cmd_reg == `SCX_CMD_SEND_NR));
    assign done_go   = (state == SCX_D_DRAIN) && !head_v && !tail_v;
    assign ack_go    = peer_ack && is_tcp;
    assign tmo_go    = peer_timeout && is_tcp && (unacked != `SCX_RESET_WORD);
    assign start_len = used_bytes(bus.tx_write_pointer, rd_ptr);
    assign pop       = head_v && net_ready;
    // ==========================================================
    // Item producer and host buffer memory
    always_comb begin
        item = '{kind: SCX_K_DATA, last: 1'b0, data: mem[cur_ptr[7:0]]};
        push = 1'b0;
        if (!tail_v && !close_go) begin
            if (state == SCX_D_SEND) begin
                push = 1'b1;
                item.last = (remain == 16'h0001) ||
                            (seg_mode && (seg_cnt == `SCX_SEG_MAX - 16'h0001));
            end else if (state == SCX_D_IDLE && pend_fin) begin
                push = 1'b1;
                item = '{kind: SCX_K_FIN, last: 1'b1, data: `SCX_RESET_BYTE};
            end else if (state == SCX_D_IDLE && keep_due) begin
                push = 1'b1;
                item = '{kind: SCX_K_KEEP, last: 1'b1, data: `SCX_RESET_BYTE};
            end
        end
    end
    always_ff @(posedge clk) begin
        if (bus.buf_wr) begin
            mem[bus.tx_write_pointer[7:0]] <= bus.buf_data;
        end
    end
    // ==========================================================
    // Command register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_reg <= `SCX_CMD_NONE;
        end else if (bus.cmd_wr) begin
            cmd_reg <= bus.cmd_code;
        end else if (exec || close_go) begin
            cmd_reg <= `SCX_CMD_NONE;
        end
    end
    // ==========================================================
    // Sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state    <= SCX_D_IDLE;
            cur_ptr  <= `SCX_RESET_WORD;
            remain   <= `SCX_RESET_WORD;
            seg_cnt  <= `SCX_RESET_WORD;
            sent_len <= `SCX_RESET_WORD;
            seg_mode <= 1'b0;
            skip_res <= 1'b0;
            dest_hw  <= '0;
        end else if (close_go) begin
            state <= SCX_D_IDLE;
        end else if (send_go) begin
            cur_ptr  <= rd_ptr;
            remain   <= start_len;
            sent_len <= start_len;
            seg_cnt  <= `SCX_RESET_WORD;
            // split only in TCP and UDP
            seg_mode <= is_tcp || (bus.sock_mode == `SCX_MODE_UDP);
            skip_res <= (cmd_reg == `SCX_CMD_SEND_NR);
            dest_hw  <= bus.dest_hw_address;
            state    <= (start_len == `SCX_RESET_WORD) ? SCX_D_DRAIN : SCX_D_SEND;
        end else if (state == SCX_D_SEND && push) begin
            cur_ptr <= cur_ptr + 16'h0001;
            remain  <= remain - 16'h0001;
            seg_cnt <= item.last ? `SCX_RESET_WORD : seg_cnt + 16'h0001;
            if (remain == 16'h0001) begin
                state <= SCX_D_DRAIN;
            end
        end else if (done_go) begin
            state <= SCX_D_IDLE;
        end
    end
    // ==========================================================
    // Two-entry output buffer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            head   <= '0;
            tail   <= '0;
            head_v <= 1'b0;
            tail_v <= 1'b0;
        end else if (pop) begin
            if (tail_v) begin
                head   <= tail;
                tail_v <= 1'b0;
            end else begin
                head   <= item;
                head_v <= push;
            end
        end else if (push) begin
            if (!head_v) begin
                head   <= item;
                head_v <= 1'b1;
            end else begin
                tail   <= item;
                tail_v <= 1'b1;
            end
        end
    end
    // ==========================================================
    // Disconnect and keep-alive
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_fin <= 1'b0;
            keep_on  <= 1'b0;
        end else if (close_go || tmo_go) begin
            pend_fin <= 1'b0;
            keep_on  <= 1'b0;
        end else if (exec && cmd_reg == `SCX_CMD_RELEASE) begin
            pend_fin <= is_tcp && ((status == `SCX_ST_CONNECTED) ||
                                   (status == `SCX_ST_PEER_CLOSE));
        end else if (exec && cmd_reg == `SCX_CMD_KEEP) begin
            keep_on <= is_tcp;
        end else if (push && item.kind == SCX_K_FIN) begin
            pend_fin <= 1'b0;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            keep_cnt <= 32'h00000000;
            keep_due <= 1'b0;
        end else if (!keep_on) begin
            keep_cnt <= 32'h00000000;
            keep_due <= 1'b0;
        end else if (keep_cnt == 32'(KEEP_CYCLES - 1)) begin
            keep_cnt <= 32'h00000000;
            keep_due <= 1'b1;
        end else begin
            keep_cnt <= keep_cnt + 32'h00000001;
            if (push && item.kind == SCX_K_KEEP) begin
                keep_due <= 1'b0;
            end
        end
    end
    // ==========================================================
    // Status and flags, set wins over clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status <= `SCX_ST_SHUT;
        end else if (close_go) begin
            status <= `SCX_ST_SHUT;
        end else if (tmo_go) begin
            status <= `SCX_ST_SHUT;
        end else if (conn_state_valid) begin
            status <= conn_state;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags <= 2'h0;
        end else begin
            flags <= (flags & ~bus.flag_clr) |
                     {tmo_go, done_go};
        end
    end
    // ==========================================================
    // Pointers and free size
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_ptr    <= `SCX_RESET_WORD;
            unacked   <= `SCX_RESET_WORD;
            free_size <= `SCX_TX_BUF_BYTES;
        end else begin
            if (done_go) begin
                rd_ptr <= cur_ptr;
            end
            if (close_go || ack_go || tmo_go) begin
                unacked <= `SCX_RESET_WORD;
            end else if (done_go && is_tcp) begin
                unacked <= unacked + sent_len;
            end
            free_size <= `SCX_TX_BUF_BYTES - used_bytes(bus.tx_write_pointer, rd_ptr) - unacked;
        end
    end
    // ==========================================================
    // Outputs
    assign bus.socket_command         = cmd_reg;
    assign bus.socket_status          = status;
    assign bus.socket_interrupt_flags = flags;
    assign bus.tx_read_pointer        = rd_ptr;
    assign bus.tx_free_size           = free_size;
    assign net_valid                  = head_v;
    assign net_data                   = head.data;
    assign net_kind                   = head.kind;
    assign net_last                   = head.last;
    assign net_skip_resolve           = skip_res;
    assign net_dest_hw                = dest_hw;
endmodule

// File: verilog/scx_host.sv
`timescale 1ns/10ps
`include "scx_params.svh"

module scx_host
    import scx_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Device side
    scx_if.host              bus,
    // Configuration
    input  wire logic [3:0]  user_mode,
    input  wire logic [47:0] user_dest,
    // Data in
    input  wire logic        wr_valid,
    input  wire logic [7:0]  wr_data,
    output logic             wr_ready,
    // Operations
    input  wire logic        op_valid,
    input  wire logic [2:0]  op_code,
    output logic             op_ready,
    output logic             op_done,
    output logic             op_refused,
    output logic             timeout_seen
);

    // ==========================================================
    // State
    scx_host_state_t state;
    logic [7:0]      code;
    logic            is_send;
    logic            sent_any;
    logic            cmd_wr;
    logic [7:0]      cmd_code;
    logic [3:0]      mode;
    logic [47:0]     dest;
    logic [15:0]     wr_ptr;
    logic            buf_wr;
    logic [7:0]      buf_data;
    logic [1:0]      clr;
    logic            refuse;
    logic [7:0]      op_cmd;
    logic            fire;
    logic [15:0]     pending;

    assign fire    = wr_valid && wr_ready;
    assign pending = wr_ptr - bus.tx_read_pointer;

    always_comb begin
        op_cmd = `SCX_CMD_SEND;
        refuse = 1'b0;
        case (scx_op_t'(op_code))
            SCX_OP_SEND_NR: begin
                op_cmd = `SCX_CMD_SEND_NR;
                refuse = (mode != `SCX_MODE_UDP) && (mode != `SCX_MODE_RAW_IP);
            end
            SCX_OP_RELEASE: op_cmd = `SCX_CMD_RELEASE;
            SCX_OP_CLOSE:   op_cmd = `SCX_CMD_CLOSE;
            SCX_OP_KEEP: begin
                op_cmd = `SCX_CMD_KEEP;
                refuse = (mode != `SCX_MODE_TCP) || !sent_any;
            end
            default: op_cmd = `SCX_CMD_SEND;
        endcase
    end

    // ==========================================================
    // Buffer writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr   <= `SCX_RESET_WORD;
            buf_wr   <= 1'b0;
            buf_data <= `SCX_RESET_BYTE;
            wr_ready <= 1'b0;
        end else begin
            buf_wr <= fire;
            if (fire) begin
                buf_data <= wr_data;
            end
            if (buf_wr) begin
                wr_ptr <= wr_ptr + 16'h0001;
            end
            // raw modes kept below segment size
            wr_ready <= !fire && !buf_wr && (bus.tx_free_size > `SCX_FREE_MARGIN) &&
                        (((mode != `SCX_MODE_RAW_IP) && (mode != `SCX_MODE_RAW_FRAME)) ||
                         (pending < `SCX_RAW_LIMIT));
        end
    end

    // ==========================================================
    // Command sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state      <= SCX_H_IDLE;
            code       <= `SCX_CMD_NONE;
            is_send    <= 1'b0;
            sent_any   <= 1'b0;
            cmd_wr     <= 1'b0;
            cmd_code   <= `SCX_CMD_NONE;
            mode       <= 4'h0;
            dest       <= '0;
            op_ready   <= 1'b0;
            op_done    <= 1'b0;
            op_refused <= 1'b0;
        end else begin
            cmd_wr     <= 1'b0;
            op_done    <= 1'b0;
            op_refused <= 1'b0;
            case (state)
                SCX_H_IDLE: begin
                    mode     <= user_mode;
                    op_ready <= 1'b1;
                    if (op_valid && op_ready) begin
                        op_ready <= 1'b0;
                        if (refuse) begin
                            op_refused <= 1'b1;
                        end else begin
                            code    <= op_cmd;
                            is_send <= (op_cmd == `SCX_CMD_SEND) ||
                                       (op_cmd == `SCX_CMD_SEND_NR);
                            if (op_cmd == `SCX_CMD_SEND_NR) begin
                                dest <= user_dest;
                            end
                            state <= SCX_H_ISSUE;
                        end
                    end
                end
                SCX_H_ISSUE: begin
                    cmd_wr   <= 1'b1;
                    cmd_code <= code;
                    state    <= SCX_H_CLEAR;
                end
                SCX_H_CLEAR: begin
                    if (!cmd_wr && bus.socket_command == `SCX_CMD_NONE) begin
                        if (is_send) begin
                            state <= SCX_H_SENT;
                        end else begin
                            op_done <= 1'b1;
                            state   <= SCX_H_IDLE;
                        end
                    end
                end
                SCX_H_SENT: begin
                    if (bus.socket_interrupt_flags[`SCX_FLAG_TXDONE]) begin
                        sent_any <= 1'b1;
                        op_done  <= 1'b1;
                        state    <= SCX_H_IDLE;
                    end
                end
                default: state <= SCX_H_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Flag clearing and timeout report
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clr          <= 2'h0;
            timeout_seen <= 1'b0;
        end else begin
            clr[`SCX_FLAG_TXDONE]  <= (state == SCX_H_SENT) &&
                                      bus.socket_interrupt_flags[`SCX_FLAG_TXDONE];
            clr[`SCX_FLAG_TIMEOUT] <= bus.socket_interrupt_flags[`SCX_FLAG_TIMEOUT] &&
                                      !clr[`SCX_FLAG_TIMEOUT];
            timeout_seen           <= bus.socket_interrupt_flags[`SCX_FLAG_TIMEOUT] &&
                                      !clr[`SCX_FLAG_TIMEOUT];
        end
    end

    // ==========================================================
    // Outputs
    assign bus.cmd_wr           = cmd_wr;
    assign bus.cmd_code         = cmd_code;
    assign bus.sock_mode        = mode;
    assign bus.dest_hw_address  = dest;
    assign bus.tx_write_pointer = wr_ptr;
    assign bus.buf_wr           = buf_wr;
    assign bus.buf_data         = buf_data;
    assign bus.flag_clr         = clr;

endmodule

// File: sim/scx_asserts.sv
`timescale 1ns/10ps
// ==========
// Interface checks
module scx_asserts (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        cmd_wr,
    input wire logic [7:0]  cmd_code,
    input wire logic [3:0]  sock_mode,
    input wire logic [15:0] tx_write_pointer,
    input wire logic [7:0]  socket_command,
    input wire logic [7:0]  socket_status,
    input wire logic [1:0]  socket_interrupt_flags,
    input wire logic [15:0] tx_read_pointer,
    input wire logic [15:0] tx_free_size
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    cmd_clear_a:
    assert property (socket_command != 8'h00 |-> ##[1:40] socket_command == 8'h00)
        else $error("command not cleared");
    close_shut_a:
    assert property ($past(socket_command) == 8'h10 && socket_command == 8'h00
        |-> ##[0:1] socket_status == 8'h00) else $error("close not shut");
    tout_shut_a:
    assert property ($rose(socket_interrupt_flags[1]) |-> ##[0:1] socket_status == 8'h00)
        else $error("timeout not shut");
    send_all_a:
    assert property ($rose(socket_interrupt_flags[0]) |-> tx_read_pointer == tx_write_pointer)
        else $error("early send done");
    free_back_a:
    assert property ($rose(socket_interrupt_flags[0]) && sock_mode != 4'h1
        |-> ##[0:2] tx_free_size == 16'h0100) else $error("free not restored");
    host_wait_a:
    assert property (cmd_wr |-> socket_command == 8'h00) else $error("command overrun");
    nores_mode_a:
    assert property (cmd_wr && cmd_code == 8'h21 |-> sock_mode inside {4'h2, 4'h3})
        else $error("bad mode");
    keep_mode_a:
    assert property (cmd_wr && cmd_code == 8'h22 |-> sock_mode == 4'h1)
        else $error("keep not tcp");
endmodule

// File: sim/tb.sv
`timescale 1ns/10ps
// ==========
// Bench
module tb import scx_pkg::*;;
    logic clk = 0, rst, wr_valid, op_valid, peer_ack, peer_timeout, conn_state_valid;
    logic wr_ready, op_ready, op_done, op_refused, timeout_seen;
    logic net_valid, net_last, net_skip_resolve, rf, ts, sk;
    logic [3:0] user_mode;
    logic [7:0] wr_data, conn_state, net_data;
    logic [2:0] op_code;
    logic [1:0] net_kind, cyc = 0;
    logic [47:0] net_dest_hw, hw, user_dest = 48'hA1B2C3D4E5F6;
    logic [15:0] nd, nl, nf, nk;
    int err_total = 0, compares = 0, n;
    wire net_ready = cyc != 2'h0;
    scx_if b();
    scx_device #(.KEEP_CYCLES(20)) u_scx_device (.clk(clk), .rst(rst), .bus(b),
        .net_valid(net_valid), .net_ready(net_ready), .net_data(net_data),
        .net_kind(net_kind), .net_last(net_last), .net_skip_resolve(net_skip_resolve),
        .net_dest_hw(net_dest_hw), .peer_ack(peer_ack), .peer_timeout(peer_timeout),
        .conn_state_valid(conn_state_valid), .conn_state(conn_state));
    scx_host u_scx_host (.clk(clk), .rst(rst), .bus(b), .user_mode(user_mode),
        .user_dest(user_dest), .wr_valid(wr_valid), .wr_data(wr_data),
        .wr_ready(wr_ready), .op_valid(op_valid), .op_code(op_code), .op_ready(op_ready),
        .op_done(op_done), .op_refused(op_refused), .timeout_seen(timeout_seen));
    scx_asserts u_scx_asserts (.clk(clk), .rst(rst), .cmd_wr(b.cmd_wr),
        .cmd_code(b.cmd_code), .sock_mode(b.sock_mode),
        .tx_write_pointer(b.tx_write_pointer), .socket_command(b.socket_command),
        .socket_status(b.socket_status), .socket_interrupt_flags(b.socket_interrupt_flags),
        .tx_read_pointer(b.tx_read_pointer), .tx_free_size(b.tx_free_size));
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 2'h1;
        if (timeout_seen) ts <= 1'b1;
        if (net_valid && net_ready) begin
            if (net_kind == SCX_K_FIN) nf <= nf + 16'h1;
            if (net_kind == SCX_K_KEEP) nk <= nk + 16'h1;
            if (net_kind == SCX_K_DATA) begin
                nd <= nd + 16'h1;
                nl <= nl + {15'h0, net_last};
                sk <= net_skip_resolve;
                hw <= net_dest_hw;
            end
        end
    end
    task tk; @(posedge clk); #1; endtask
    task chk(input logic [47:0] s, e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %0t %h %h", $time, s, e);
        end
    endtask
    task tally_and_finish;
        $display("err_total=%0d compares=%0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task put(input int k);
        wr_valid = 1'b1;
        repeat (k) begin
            while (!wr_ready) tk;
            tk;
            wr_data = wr_data + 8'h01;
        end
        wr_valid = 1'b0;
    endtask
    task op(input logic [2:0] c);
        op_code = c;
        op_valid = 1'b1;
        while (!op_ready) tk;
        tk;
        op_valid = 1'b0;
        for (n = 0; n < 3000 && !(op_done || op_refused); n++) tk;
        rf = op_refused;
        repeat (4) tk;
    endtask
    task cs; conn_state_valid = 1'b1; tk; conn_state_valid = 1'b0; endtask
    task t_seg;
        nd = 0; nl = 0;
        put(16'h41);
        op(SCX_OP_SEND);
        chk(nd, 16'h41);
        chk(nl, 16'h2);
        chk(b.tx_free_size, 16'h0100);
    endtask
    task t_nores;
        put(1);
        op(SCX_OP_SEND_NR);
        chk(sk, 1'b1);
        chk(hw, user_dest);
        user_mode = 4'h1;
        tk;
        op(SCX_OP_SEND_NR);
        chk(rf, 1'b1);
    endtask
    task t_tcp;
        cs;
        put(1);
        op(SCX_OP_SEND);
        chk(b.tx_free_size, 16'h00FF);
        peer_ack = 1'b1; tk; peer_ack = 1'b0; repeat (3) tk;
        chk(b.tx_free_size, 16'h0100);
        nk = 0; op(SCX_OP_KEEP); repeat (60) tk;
        chk(nk > 16'h1, 1'b1);
        nf = 0; op(SCX_OP_RELEASE);
        chk(nf, 16'h1);
    endtask
    task t_close;
        cs; nf = 0;
        op(SCX_OP_CLOSE);
        chk(b.socket_status, 8'h00);
        chk(nf, 16'h0);
    endtask
    task t_tout;
        cs; put(1); op(SCX_OP_SEND); ts = 0;
        peer_timeout = 1'b1; tk; peer_timeout = 1'b0; repeat (4) tk;
        chk(ts, 1'b1);
        chk(b.socket_status, 8'h00);
    endtask
    initial begin
        {wr_valid, op_valid, peer_ack, peer_timeout, conn_state_valid} = 5'h00;
        {rst, user_mode, wr_data, op_code, conn_state} = {1'b1, 4'h2, 8'h00, 3'h0, 8'h17};
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        tk; tk;
        t_seg; t_nores; t_tcp; t_close; t_tout;
        tally_and_finish;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        tally_and_finish;
    end
endmodule
